// [hdl/ric_pkg.sv]
// Constants, register map and state type for the relay input conditioner.
// Assumes a single 25 MHz clock and an APB master on the register side.
// What this block does
// - Per field input polarity: open type activates rising, closed type falling.
// - One delay per field input, 0.00 to 60.00 s, for both directions.
// - Qualified active edge sets an on-event flag when its enable is on.
// - Qualified inactive edge sets an off-event flag when its enable is on.
// - Active edge raises an alarm display request when alarm display is enabled.
// - Saturating-range 16-bit active edge counter per input, preset by privileged write.
// - Each input group has ac or dc mode; configurer picks ac for ac supply.
// - Qualified state of every field input is readable, 1 means active.
// - Twenty stored soft inputs act as signal sources like field inputs.
// - A soft input write takes effect well within 5 ms.
// - Panel, communication bus and configuration tool may all overwrite soft inputs.
// - Twenty soft outputs with readable status.
// - Direct soft output write accepted only while force flag is on.
package ric_pkg;

  // ==========================================
  // Sizes
  localparam int NUM_FIELD = 8;
  localparam int GROUP_SIZE = 4;
  localparam int NUM_GROUP = 2;
  localparam int NUM_SOFT = 20;
  localparam int DLY_W = 13;
  localparam int CNT_W = 16;
  localparam int TDIV_W = 18;

  // ==========================================
  // Timing
  localparam int CLK_HZ = 25000000;
  localparam int TICK_MS = 10;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int DLY_MAX_S = 60;
  localparam logic [DLY_W-1:0] DLY_MAX = 13'(DLY_MAX_S * 1000 / TICK_MS);
  localparam int SOFT_IN_MS = 5;
  localparam int SOFT_IN_CYCLES = CLK_HZ / 1000 * SOFT_IN_MS;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;

  // ==========================================
  // Register map, byte addresses
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] EVCFG_OFS = 8'h04;
  localparam logic [7:0] POLAR_OFS = 8'h08;
  localparam logic [7:0] STATE_OFS = 8'h0C;
  localparam logic [7:0] SOFTIN_OFS = 8'h10;
  localparam logic [7:0] SOFTOUT_OFS = 8'h14;
  localparam logic [7:0] ISTS_OFS = 8'h18;
  localparam logic [7:0] IEN_OFS = 8'h1C;
  localparam logic [7:0] ICLR_OFS = 8'h20;
  localparam logic [7:0] DLY_BASE = 8'h40;
  localparam logic [7:0] CNT_BASE = 8'h60;

  // Field positions
  localparam int CTRL_FORCE_BIT = 0;
  localparam int CTRL_AC_LSB = 1;
  localparam int EV_ON_LSB = 0;
  localparam int EV_OFF_LSB = 8;
  localparam int EV_ALM_LSB = 16;
  localparam int EV_W = 24;

  // Reset values
  localparam logic [DLY_W-1:0] DLY_RST = 13'h0000;
  localparam logic [NUM_FIELD-1:0] EVEN_RST = 8'h00;

  typedef struct packed {
    logic force_on;
    logic [NUM_GROUP-1:0] ac_mode;
    logic [NUM_FIELD-1:0] on_en;
    logic [NUM_FIELD-1:0] off_en;
    logic [NUM_FIELD-1:0] alm_en;
    logic [NUM_FIELD-1:0] nc;
    logic [NUM_FIELD-1:0][DLY_W-1:0] dly;
    logic [NUM_FIELD-1:0][DLY_W-1:0] qcnt;
    logic [NUM_FIELD-1:0] qual;
    logic [NUM_FIELD-1:0] ac_seen;
    logic [NUM_FIELD-1:0] ac_hold;
    logic [NUM_FIELD-1:0][CNT_W-1:0] ecnt;
    logic [NUM_SOFT-1:0] soft_in;
    logic [NUM_SOFT-1:0] soft_out;
    logic [NUM_FIELD-1:0] alarm;
    logic [EV_W-1:0] ists;
    logic [EV_W-1:0] ien;
    logic [31:0] rdata;
    logic slverr;
    logic [TDIV_W-1:0] tdiv;
  } ric_state_t;

endpackage : ric_pkg

// [hdl/ric_top.sv]
// Relay input conditioner: field input qualification, soft inputs and
// soft outputs, event flags, edge counters and an APB register file.
// Assumes field levels already synchronous to core_clk_i.
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps

module ric_top #(
  parameter int TICK_CYCLES = ric_pkg::TICK_CYCLES // Cycles per 10 ms tick
) (
  input wire logic core_clk_i, // 25 MHz clock
  input wire logic rst_i, // Async reset, high
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB write
  input wire logic [7:0] paddr_i, // APB byte address
  input wire logic [31:0] pwdata_i, // APB write data
  input wire logic [2:0] pprot_i, // APB protection, bit0 privileged
  output logic [31:0] prdata_o, // APB read data
  output logic pready_o, // APB ready
  output logic pslverr_o, // APB error
  input wire logic [ric_pkg::NUM_FIELD-1:0] field_input_i, // Raw contact levels
  input wire logic [ric_pkg::NUM_SOFT-1:0] soft_out_src_i, // Matrix drive of soft outputs
  input wire logic panel_we_i, // Panel soft input write strobe
  input wire logic [4:0] panel_idx_i, // Panel soft input index
  input wire logic panel_val_i, // Panel soft input value
  input wire logic comm_we_i, // Comm bus soft input write strobe
  input wire logic [4:0] comm_idx_i, // Comm bus soft input index
  input wire logic comm_val_i, // Comm bus soft input value
  output logic [ric_pkg::NUM_FIELD-1:0] field_state_o, // Qualified states
  output logic [ric_pkg::NUM_SOFT-1:0] soft_input_o, // Soft input states
  output logic [ric_pkg::NUM_SOFT-1:0] soft_output_o, // Soft output states
  output logic [ric_pkg::NUM_FIELD-1:0] alarm_req_o, // Alarm display pulse
  output logic irq_o // Interrupt level
);
  import ric_pkg::*;

  ric_state_t s_reg;
  ric_state_t s_next;

  // ==========================================
  // Helpers
  function automatic logic in_win(input logic [7:0] a, input logic [7:0] base);
    in_win = (a >= base) && (a < base + 8'(NUM_FIELD * 4)) && (a[1:0] == 2'b00);
  endfunction : in_win

  function automatic logic [2:0] win_idx(input logic [7:0] a, input logic [7:0] base);
    logic [7:0] d;
    d = a - base;
    win_idx = d[4:2];
  endfunction : win_idx

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    sat_inc = (v == CNT_MAX) ? v : v + 16'h0001;
  endfunction : sat_inc

  // ==========================================
  // Next state
  always_comb begin
    logic tick;
    logic lvl;
    logic rise;
    logic fall;
    logic setup;
    logic wr;
    logic [EV_W-1:0] ev;
    logic [EV_W-1:0] clr;
    logic [2:0] k;
    tick = 1'b0;
    setup = 1'b0;
    wr = 1'b0;
    lvl = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    ev = '0;
    clr = '0;
    k = '0;
    s_next = s_reg;
    s_next.alarm = '0;

    // Shared 10 ms time base; keeps per-input timers narrow
    tick = (s_reg.tdiv == TDIV_W'(TICK_CYCLES - 1));
    s_next.tdiv = tick ? '0 : s_reg.tdiv + 18'h00001;

    for (int i = 0; i < NUM_FIELD; i++) begin
      // Ac mode: any high sample inside a tick window counts as energised
      s_next.ac_seen[i] = tick ? 1'b0 : (s_reg.ac_seen[i] | field_input_i[i]);
      if (tick) begin
        s_next.ac_hold[i] = s_reg.ac_seen[i] | field_input_i[i];
      end
      lvl = s_reg.ac_mode[i / GROUP_SIZE] ? s_reg.ac_hold[i] : field_input_i[i];
      lvl = lvl ^ s_reg.nc[i];
      if (lvl == s_reg.qual[i]) begin
        s_next.qcnt[i] = '0;
      end else if (s_reg.dly[i] == '0) begin
        s_next.qual[i] = lvl;
        s_next.qcnt[i] = '0;
      end else if (tick) begin
        // One extra tick so a partial first window never shortens the delay
        if (s_reg.qcnt[i] == s_reg.dly[i]) begin
          s_next.qual[i] = lvl;
          s_next.qcnt[i] = '0;
        end else begin
          s_next.qcnt[i] = s_reg.qcnt[i] + 13'h0001;
        end
      end
      rise = s_next.qual[i] & ~s_reg.qual[i];
      fall = s_reg.qual[i] & ~s_next.qual[i];
      if (rise) begin
        s_next.ecnt[i] = sat_inc(s_reg.ecnt[i]);
      end
      ev[EV_ON_LSB + i] = rise & s_reg.on_en[i];
      ev[EV_OFF_LSB + i] = fall & s_reg.off_en[i];
      ev[EV_ALM_LSB + i] = rise & s_reg.alm_en[i];
      s_next.alarm[i] = rise & s_reg.alm_en[i];
    end

    // Soft outputs follow the matrix unless forced
    if (!s_reg.force_on) begin
      s_next.soft_out = soft_out_src_i;
    end

    // Soft input writers; later writer wins in a shared cycle
    if (panel_we_i && (panel_idx_i < 5'(NUM_SOFT))) begin
      s_next.soft_in[panel_idx_i] = panel_val_i;
    end
    if (comm_we_i && (comm_idx_i < 5'(NUM_SOFT))) begin
      s_next.soft_in[comm_idx_i] = comm_val_i;
    end

    // ==========================================
    // APB slave: decode in setup, act in access
    setup = psel_i & ~penable_i;
    wr = psel_i & penable_i & pwrite_i & ~s_reg.slverr;
    if (setup) begin
      s_next.rdata = '0;
      s_next.slverr = 1'b0;
      case (paddr_i)
        CTRL_OFS: begin
          s_next.rdata[CTRL_FORCE_BIT] = s_reg.force_on;
          s_next.rdata[CTRL_AC_LSB +: NUM_GROUP] = s_reg.ac_mode;
        end
        EVCFG_OFS: begin
          s_next.rdata[EV_W-1:0] = {s_reg.alm_en, s_reg.off_en, s_reg.on_en};
        end
        POLAR_OFS: s_next.rdata[NUM_FIELD-1:0] = s_reg.nc;
        STATE_OFS: s_next.rdata[NUM_FIELD-1:0] = s_reg.qual;
        SOFTIN_OFS: s_next.rdata[NUM_SOFT-1:0] = s_reg.soft_in;
        SOFTOUT_OFS: s_next.rdata[NUM_SOFT-1:0] = s_reg.soft_out;
        ISTS_OFS: s_next.rdata[EV_W-1:0] = s_reg.ists;
        IEN_OFS: s_next.rdata[EV_W-1:0] = s_reg.ien;
        ICLR_OFS: s_next.rdata = '0;
        default: begin
          if (in_win(paddr_i, DLY_BASE)) begin
            s_next.rdata[DLY_W-1:0] = s_reg.dly[win_idx(paddr_i, DLY_BASE)];
          end else if (in_win(paddr_i, CNT_BASE)) begin
            s_next.rdata[CNT_W-1:0] = s_reg.ecnt[win_idx(paddr_i, CNT_BASE)];
            // Preset needs a privileged access
            s_next.slverr = pwrite_i & ~pprot_i[0];
          end else begin
            s_next.slverr = 1'b1;
          end
        end
      endcase
    end

    if (wr) begin
      case (paddr_i)
        CTRL_OFS: begin
          s_next.force_on = pwdata_i[CTRL_FORCE_BIT];
          s_next.ac_mode = pwdata_i[CTRL_AC_LSB +: NUM_GROUP];
        end
        EVCFG_OFS: begin
          s_next.on_en = pwdata_i[EV_ON_LSB +: NUM_FIELD];
          s_next.off_en = pwdata_i[EV_OFF_LSB +: NUM_FIELD];
          s_next.alm_en = pwdata_i[EV_ALM_LSB +: NUM_FIELD];
        end
        POLAR_OFS: s_next.nc = pwdata_i[NUM_FIELD-1:0];
        SOFTIN_OFS: s_next.soft_in = pwdata_i[NUM_SOFT-1:0];
        SOFTOUT_OFS: begin
          if (s_reg.force_on) begin
            s_next.soft_out = pwdata_i[NUM_SOFT-1:0];
          end
        end
        IEN_OFS: s_next.ien = pwdata_i[EV_W-1:0];
        ICLR_OFS: clr = pwdata_i[EV_W-1:0];
        default: begin
          if (in_win(paddr_i, DLY_BASE)) begin
            k = win_idx(paddr_i, DLY_BASE);
            // Out-of-range delay is clipped to 60.00 s
            s_next.dly[k] = (pwdata_i[DLY_W-1:0] > DLY_MAX) ? DLY_MAX : pwdata_i[DLY_W-1:0];
            s_next.qcnt[k] = '0;
          end else if (in_win(paddr_i, CNT_BASE)) begin
            s_next.ecnt[win_idx(paddr_i, CNT_BASE)] = pwdata_i[CNT_W-1:0];
          end
        end
      endcase
    end

    // Hardware set beats software clear
    s_next.ists = (s_reg.ists & ~clr) | ev;
  end

  // ==========================================
  // State register
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================
  // Outputs
  assign prdata_o = s_reg.rdata;
  assign pslverr_o = s_reg.slverr & psel_i & penable_i;
  assign pready_o = 1'b1;
  assign field_state_o = s_reg.qual;
  assign soft_input_o = s_reg.soft_in;
  assign soft_output_o = s_reg.soft_out;
  assign alarm_req_o = s_reg.alarm;
  assign irq_o = |(s_reg.ists & s_reg.ien);

endmodule : ric_top

// [tb/ric_assertions.sv]
// Port checker for ric_top: soft inputs, soft outputs, alarms and APB errors.
// Assumes one clock and a high-active reset, attached by bind.
`timescale 1ns/1ps
module ric_assertions (
  input wire logic core_clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB write
  input wire logic [7:0] paddr_i, // APB address
  input wire logic [2:0] pprot_i, // APB protection
  input wire logic pslverr_o, // APB error
  input wire logic panel_we_i, // Panel strobe
  input wire logic [4:0] panel_idx_i, // Panel index
  input wire logic panel_val_i, // Panel value
  input wire logic comm_we_i, // Comm strobe
  input wire logic [4:0] comm_idx_i, // Comm index
  input wire logic comm_val_i, // Comm value
  input wire logic [19:0] soft_out_src_i, // Matrix drive
  input wire logic [19:0] soft_input_o, // Soft inputs
  input wire logic [19:0] soft_output_o, // Soft outputs
  input wire logic [7:0] field_state_o, // Qualified states
  input wire logic [7:0] alarm_req_o // Alarm pulses
);
  wire apb_wr = psel_i && penable_i && pwrite_i;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================
  // Properties
  property p_sin_pnl;
    panel_we_i && panel_idx_i < 5'h14 && !comm_we_i && !apb_wr |=> soft_input_o[$past(panel_idx_i)] == $past(panel_val_i);
  endproperty
  a_sin_pnl: assert property (p_sin_pnl) else $error("panel write lost");
  property p_sin_com;
    comm_we_i && comm_idx_i < 5'h14 && !apb_wr |=> soft_input_o[$past(comm_idx_i)] == $past(comm_val_i);
  endproperty
  a_sin_com: assert property (p_sin_com) else $error("comm write lost");
  property p_sin_hold;
    $changed(soft_input_o) |-> $past(panel_we_i || comm_we_i || apb_wr);
  endproperty
  a_sin_hold: assert property (p_sin_hold) else $error("soft input moved alone");
  property p_sin_rng;
    panel_we_i && panel_idx_i > 5'h13 && !comm_we_i && !apb_wr |=> $stable(soft_input_o);
  endproperty
  a_sin_rng: assert property (p_sin_rng) else $error("bad index took effect");
  property p_sout;
    $changed(soft_output_o) |-> soft_output_o == $past(soft_out_src_i) || $past(apb_wr);
  endproperty
  a_sout: assert property (p_sout) else $error("soft output from nowhere");
  property p_alm_edge;
    |alarm_req_o |-> (alarm_req_o & ~(field_state_o & ~$past(field_state_o))) == 8'h00;
  endproperty
  a_alm_edge: assert property (p_alm_edge) else $error("alarm without active edge");
  property p_alm_pls;
    |alarm_req_o |=> (alarm_req_o & $past(alarm_req_o)) == 8'h00;
  endproperty
  a_alm_pls: assert property (p_alm_pls) else $error("alarm longer than a pulse");
  property p_err_cnt;
    apb_wr && !pprot_i[0] && paddr_i >= 8'h60 && paddr_i < 8'h80 |-> pslverr_o;
  endproperty
  a_err_cnt: assert property (p_err_cnt) else $error("unprivileged preset accepted");
  property p_err_gate;
    pslverr_o |-> psel_i && penable_i;
  endproperty
  a_err_gate: assert property (p_err_gate) else $error("error outside access");
  c_alm: cover property (|alarm_req_o);
  c_err: cover property (pslverr_o);
  c_both: cover property (panel_we_i ##1 comm_we_i);
endmodule : ric_assertions

// [tb/ric_contacts.sv]
// Field contact model: raw levels at the terminals from a wanted level.
// Assumes a dc control voltage; an ac feed is mimicked by toggling chatter bits, as t_ac does for input 4 of group 1.
`timescale 1ns/1ps
module ric_contacts (
  input wire logic clk_i, // Core clock
  input wire logic [7:0] level_i, // Wanted contact levels
  input wire logic [7:0] chatter_i, // Bits reversed this cycle
  output logic [7:0] field_o // Levels at the terminals
);
  // Chatter lets a test break a held level for one cycle
  always_ff @(posedge clk_i) begin
    field_o <= level_i ^ chatter_i;
  end
endmodule : ric_contacts

// [tb/ric_tb_top.sv]
// Testbench for ric_top: APB master tasks, contact model, one task per scenario.
// Assumes the checker and contact model are compiled first.
`timescale 1ns/1ps
module ric_tb_top;
  import ric_pkg::*;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, perr, e, rdy, irq;
  logic pnl_we = 1'b0, pnl_val = 1'b0, com_we = 1'b0, com_val = 1'b0;
  logic [4:0] pnl_idx = 5'h00, com_idx = 5'h00;
  logic [7:0] addr = 8'h00, lvl = 8'h00, flip = 8'h00, fin, st, alm;
  logic [31:0] wd = 32'h0, prd, rd;
  logic [2:0] prot = 3'h0;
  logic [19:0] src = 20'h0, sin, sout;
  int err_total = 0, n_checks = 0, cyc = 0, alm_n = 0;
  ric_contacts u_ct (.clk_i(clk), .level_i(lvl), .chatter_i(flip), .field_o(fin));
  ric_top #(.TICK_CYCLES(10)) uut (.core_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(addr), .pwdata_i(wd), .pprot_i(prot), .prdata_o(prd), .pready_o(rdy), .pslverr_o(perr),
    .field_input_i(fin), .soft_out_src_i(src), .panel_we_i(pnl_we), .panel_idx_i(pnl_idx), .panel_val_i(pnl_val),
    .comm_we_i(com_we), .comm_idx_i(com_idx), .comm_val_i(com_val), .field_state_o(st), .soft_input_o(sin),
    .soft_output_o(sout), .alarm_req_o(alm), .irq_o(irq));
  initial begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    alm_n <= alm_n + $countones(alm);
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      end_sim();
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    addr <= a;
    wd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 20);
    rd = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_n
  task automatic t_edge;
    apb(1'b1, EVCFG_OFS, 32'h00FFFFFF);
    apb(1'b1, POLAR_OFS, 32'h2);
    wait_n(3);
    chk({24'h0, st}, 32'h2, "state_nc");
    lvl <= 8'h03;
    wait_n(4);
    chk({24'h0, st}, 32'h1, "state_no");
    apb(1'b0, ISTS_OFS, 32'h0);
    chk(rd, 32'h00030203, "ists");
    chk(alm_n, 32'h2, "alarms");
    apb(1'b0, CNT_BASE + 8'h04, 32'h0);
    chk(rd, 32'h1, "count1");
    apb(1'b1, ICLR_OFS, 32'h00FFFFFF);
  endtask : t_edge
  task automatic t_dly;
    apb(1'b1, DLY_BASE + 8'h1C, 32'hFFFF);
    apb(1'b0, DLY_BASE + 8'h1C, 32'h0);
    chk(rd, 32'(DLY_MAX), "dly_clip");
    apb(1'b1, DLY_BASE + 8'h08, 32'h3);
    lvl <= 8'h07;
    wait_n(28);
    flip <= 8'h04;
    wait_n(1);
    flip <= 8'h00;
    wait_n(14);
    chk({31'h0, st[2]}, 32'h0, "dly_restart");
    wait_n(35);
    chk({31'h0, st[2]}, 32'h1, "dly_done");
  endtask : t_dly
  task automatic t_irq;
    chk({31'h0, irq}, 32'h0, "irq_masked");
    apb(1'b1, IEN_OFS, 32'h4);
    wait_n(1);
    chk({31'h0, irq}, 32'h1, "irq_on");
    apb(1'b1, ICLR_OFS, 32'h4);
    wait_n(1);
    chk({31'h0, irq}, 32'h0, "irq_clr");
  endtask : t_irq
  task automatic t_soft;
    @(posedge clk);
    pnl_we <= 1'b1;
    pnl_idx <= 5'h03;
    pnl_val <= 1'b1;
    @(posedge clk);
    pnl_idx <= 5'h13;
    pnl_val <= 1'b0;
    com_we <= 1'b1;
    com_idx <= 5'h13;
    com_val <= 1'b1;
    @(posedge clk);
    com_we <= 1'b0;
    pnl_idx <= 5'h14;
    pnl_val <= 1'b1;
    @(posedge clk);
    pnl_we <= 1'b0;
    wait_n(1);
    chk({12'h0, sin}, 32'h80008, "soft_in");
    apb(1'b1, SOFTIN_OFS, 32'h1);
    wait_n(1);
    chk({12'h0, sin}, 32'h1, "soft_in_apb");
  endtask : t_soft
  task automatic t_sout;
    src <= 20'hABCDE;
    apb(1'b1, SOFTOUT_OFS, 32'h1);
    wait_n(1);
    chk({12'h0, sout}, 32'hABCDE, "sout_noforce");
    apb(1'b1, CTRL_OFS, 32'h1);
    src <= 20'h0;
    apb(1'b1, SOFTOUT_OFS, 32'h12345);
    apb(1'b0, SOFTOUT_OFS, 32'h0);
    chk(rd, 32'h12345, "sout_force");
    apb(1'b1, CTRL_OFS, 32'h0);
  endtask : t_sout
  task automatic t_cnt;
    apb(1'b1, CNT_BASE, 32'hFFFE);
    chk({31'h0, e}, 32'h1, "cnt_unpriv");
    prot <= 3'h1;
    apb(1'b1, CNT_BASE, 32'hFFFE);
    for (int i = 0; i < 2; i++) begin
      lvl <= 8'h06;
      wait_n(4);
      lvl <= 8'h07;
      wait_n(4);
    end
    apb(1'b0, CNT_BASE, 32'h0);
    chk(rd, 32'hFFFF, "cnt_sat");
  endtask : t_cnt
  task automatic t_ac;
    // Group 1 in ac mode; input 4 toggles as an ac-fed contact would
    apb(1'b1, CTRL_OFS, 32'h4);
    lvl <= 8'h17;
    for (int i = 0; i < 40; i++) begin
      flip <= flip ^ 8'h10;
      wait_n(1);
      if (i > 37) begin
        chk({31'h0, st[4]}, 32'h1, "ac_steady");
      end
    end
    flip <= 8'h00;
    lvl <= 8'h07;
  endtask : t_ac
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim
  initial begin
    wait_n(5);
    rst <= 1'b0;
    t_edge();
    t_dly();
    t_irq();
    t_soft();
    t_sout();
    t_cnt();
    t_ac();
    end_sim();
  end
endmodule : ric_tb_top
bind ric_top ric_assertions u_chk (.core_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pprot_i,
  .pslverr_o, .panel_we_i, .panel_idx_i, .panel_val_i, .comm_we_i, .comm_idx_i, .comm_val_i, .soft_out_src_i,
  .soft_input_o, .soft_output_o, .field_state_o, .alarm_req_o);
